/* hw/sst_pkg.sv */
// Shared constants and types for the subtract, swap and table execution unit
package sst_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SST_DATA_W = 8;
    localparam int SST_FILE_ADDR_W = 7;
    localparam int SST_ROM_WORD_W = 14;
    localparam int SST_TBL_PTR_W = 3;
    localparam int SST_ROM_ADDR_W = SST_TBL_PTR_W + SST_DATA_W;
    localparam int SST_TBL_DATA_W = 6;
    localparam int SST_SEC_INDEX_W = 4;

    // ------------------------------------------------------------
    // Field positions and limits
    // ------------------------------------------------------------
    localparam int SST_ROM_LOW_MSB = 7;
    localparam int SST_ROM_HIGH_LSB = 8;
    localparam int SST_ROM_HIGH_MSB = 13;
    localparam logic [SST_SEC_INDEX_W-1:0] SST_SEC_INDEX_MAX = 4'hE;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [SST_DATA_W-1:0] SST_ACCUM_RESET = 8'h00;
    localparam logic [SST_TBL_DATA_W-1:0] SST_TBL_DATA_RESET = 6'h00;
    localparam logic [SST_DATA_W-1:0] SST_T0_MODE_RESET = 8'h00;
    localparam logic SST_FLAG_RESET = 1'b0;

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam int SST_TABLE_CYCLES = 2;

    // ------------------------------------------------------------
    // Operation codes from the instruction decoder
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SST_OP_NONE = 3'h0,
        SST_OP_SUB_FILE = 3'h1,
        SST_OP_SUB_IMM = 3'h2,
        SST_OP_SWAP = 3'h3,
        SST_OP_TABLE = 3'h4,
        SST_OP_LOAD_SEC = 3'h5,
        SST_OP_LOAD_T0 = 3'h6
    } sst_op_t;

    // ------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SST_ST_IDLE = 2'b01,
        SST_ST_TABLE = 2'b10
    } sst_state_t;

endpackage

/* hw/sst_alu.sv */
// Combinational subtractor and nibble swapper
`timescale 1ns/1ps
module sst_alu
    import sst_pkg::*;
(
    input wire logic [SST_DATA_W-1:0] minuend,
    input wire logic [SST_DATA_W-1:0] subtrahend,
    output logic [SST_DATA_W-1:0] diff,
    output logic zero,
    output logic digit_carry,
    output logic carry,
    output logic [SST_DATA_W-1:0] swapped
);

    logic [SST_DATA_W:0] full_sum;
    logic [4:0] low_sum;

    always_comb begin
        // Two's complement: minuend + ~subtrahend + 1
        full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
        low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
        diff = full_sum[SST_DATA_W-1:0];
        zero = (full_sum[SST_DATA_W-1:0] == 8'h00); // RL9
        carry = full_sum[SST_DATA_W]; // RL2
        digit_carry = low_sum[4]; // RL9
        swapped = {minuend[3:0], minuend[7:4]}; // RL4
    end

endmodule // sst_alu

/* hw/sst_exec.sv */
// Execution unit: subtract, nibble swap, ROM table read, SFR loads
//
// What this block does
// RL1 - File minus accumulator, flags, destination bit
// RL2 - Carry is inverted borrow on subtraction
// RL3 - Immediate minus accumulator into accumulator
// RL4 - Swap file nibbles, flags kept, destination selectable
// RL5 - Two-cycle ROM read, low byte to accumulator
// RL6 - ROM bits 13:8 into table high data
// RL7 - Accumulator to secondary page register 0..14
// RL8 - Accumulator to timer0 mode, flags kept
// RL9 - Zero on zero result, digit carry no-borrow
`timescale 1ns/1ps
module sst_exec
    import sst_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic OP_VALID,
    input wire logic [2:0] OP_CODE,
    input wire logic OP_DEST,
    input wire logic [SST_FILE_ADDR_W-1:0] OP_FILE_ADDR,
    input wire logic [SST_DATA_W-1:0] OP_IMMEDIATE,
    input wire logic [SST_SEC_INDEX_W-1:0] OP_SEC_INDEX,
    input wire logic [SST_DATA_W-1:0] FILE_RDATA,
    input wire logic [SST_TBL_PTR_W-1:0] TABLE_HIGH_POINTER,
    input wire logic [SST_ROM_WORD_W-1:0] ROM_DATA,
    output logic BUSY,
    output logic [SST_DATA_W-1:0] ACCUMULATOR,
    output logic ZERO_FLAG,
    output logic DIGIT_CARRY_FLAG,
    output logic CARRY_FLAG,
    output logic FILE_WE,
    output logic [SST_FILE_ADDR_W-1:0] FILE_WADDR,
    output logic [SST_DATA_W-1:0] FILE_WDATA,
    output logic [SST_ROM_ADDR_W-1:0] ROM_ADDR,
    output logic [SST_TBL_DATA_W-1:0] TABLE_HIGH_DATA,
    output logic [SST_DATA_W-1:0] TIMER0_MODE_REGISTER,
    output logic SEC_WE,
    output logic [SST_SEC_INDEX_W-1:0] SEC_INDEX,
    output logic [SST_DATA_W-1:0] SEC_WDATA
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        sst_state_t state;
        logic [SST_DATA_W-1:0] accum;
        logic zero;
        logic digit_carry;
        logic carry;
        logic file_we;
        logic [SST_FILE_ADDR_W-1:0] file_waddr;
        logic [SST_DATA_W-1:0] file_wdata;
        logic [SST_ROM_ADDR_W-1:0] rom_addr;
        logic [SST_TBL_DATA_W-1:0] tbl_data;
        logic [SST_DATA_W-1:0] t0_mode;
        logic sec_we;
        logic [SST_SEC_INDEX_W-1:0] sec_index;
        logic [SST_DATA_W-1:0] sec_wdata;
    } sst_core_t;

    localparam sst_core_t SST_CORE_RESET = '{
        state: SST_ST_IDLE,
        accum: SST_ACCUM_RESET,
        zero: SST_FLAG_RESET,
        digit_carry: SST_FLAG_RESET,
        carry: SST_FLAG_RESET,
        file_we: 1'b0,
        file_waddr: 7'h00,
        file_wdata: 8'h00,
        rom_addr: 11'h000,
        tbl_data: SST_TBL_DATA_RESET,
        t0_mode: SST_T0_MODE_RESET,
        sec_we: 1'b0,
        sec_index: 4'h0,
        sec_wdata: 8'h00
    };

    sst_core_t core_reg;
    sst_core_t core_next;

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    logic [SST_DATA_W-1:0] alu_minuend;
    logic [SST_DATA_W-1:0] alu_diff;
    logic [SST_DATA_W-1:0] alu_swapped;
    logic alu_zero;
    logic alu_digit_carry;
    logic alu_carry;
    sst_op_t op;

    assign op = sst_op_t'(OP_CODE);

    // ------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------
    // Immediate subtraction takes the operand, all others the file value
    assign alu_minuend = (op == SST_OP_SUB_IMM) ? OP_IMMEDIATE : FILE_RDATA;

    sst_alu u_alu (
        .minuend(alu_minuend),
        .subtrahend(core_reg.accum),
        .diff(alu_diff),
        .zero(alu_zero),
        .digit_carry(alu_digit_carry),
        .carry(alu_carry),
        .swapped(alu_swapped)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        core_next = core_reg;
        // Write strobes last one cycle
        core_next.file_we = 1'b0;
        core_next.sec_we = 1'b0;
        case (core_reg.state)
            SST_ST_IDLE: begin
                if (OP_VALID) begin
                    case (op)
                        SST_OP_SUB_FILE: begin
                            core_next.zero = alu_zero; // RL1
                            core_next.digit_carry = alu_digit_carry; // RL9
                            core_next.carry = alu_carry; // RL2
                            if (OP_DEST) begin
                                core_next.file_we = 1'b1; // RL1
                                core_next.file_waddr = OP_FILE_ADDR;
                                core_next.file_wdata = alu_diff;
                            end else begin
                                core_next.accum = alu_diff; // RL1
                            end
                        end
                        SST_OP_SUB_IMM: begin
                            core_next.accum = alu_diff; // RL3
                            core_next.zero = alu_zero; // RL3
                            core_next.digit_carry = alu_digit_carry; // RL9
                            core_next.carry = alu_carry; // RL2
                        end
                        SST_OP_SWAP: begin
                            if (OP_DEST) begin
                                core_next.file_we = 1'b1; // RL4
                                core_next.file_waddr = OP_FILE_ADDR;
                                core_next.file_wdata = alu_swapped;
                            end else begin
                                core_next.accum = alu_swapped; // RL4
                            end
                        end
                        SST_OP_TABLE: begin
                            // First cycle presents the ROM address
                            core_next.rom_addr = {TABLE_HIGH_POINTER,
                                core_reg.accum}; // RL5
                            core_next.state = SST_ST_TABLE; // RL5
                        end
                        SST_OP_LOAD_SEC: begin
                            // Index 15 does not exist and is ignored
                            if (OP_SEC_INDEX <= SST_SEC_INDEX_MAX) begin
                                core_next.sec_we = 1'b1; // RL7
                                core_next.sec_index = OP_SEC_INDEX;
                                core_next.sec_wdata = core_reg.accum; // RL7
                            end
                        end
                        SST_OP_LOAD_T0: begin
                            core_next.t0_mode = core_reg.accum; // RL8
                        end
                        default: begin
                            // Codes 0 and 7 change nothing
                            core_next.state = SST_ST_IDLE;
                        end
                    endcase
                end
            end
            SST_ST_TABLE: begin
                // Second cycle captures the addressed ROM word
                // Operations offered in this cycle are dropped
                core_next.accum = ROM_DATA[SST_ROM_LOW_MSB:0]; // RL5
                core_next.tbl_data =
                    ROM_DATA[SST_ROM_HIGH_MSB:SST_ROM_HIGH_LSB]; // RL6
                core_next.state = SST_ST_IDLE;
            end
            default: begin
                core_next.state = SST_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            core_reg <= SST_CORE_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Decoder must hold off while the ROM word is fetched
    assign BUSY = (core_reg.state == SST_ST_TABLE); // RL5
    // Data outputs come straight from the state record
    assign ACCUMULATOR = core_reg.accum;
    assign ZERO_FLAG = core_reg.zero;
    assign DIGIT_CARRY_FLAG = core_reg.digit_carry;
    assign CARRY_FLAG = core_reg.carry;
    assign FILE_WE = core_reg.file_we;
    assign FILE_WADDR = core_reg.file_waddr;
    assign FILE_WDATA = core_reg.file_wdata;
    assign ROM_ADDR = core_reg.rom_addr;
    assign TABLE_HIGH_DATA = core_reg.tbl_data;
    assign TIMER0_MODE_REGISTER = core_reg.t0_mode;
    assign SEC_WE = core_reg.sec_we;
    assign SEC_INDEX = core_reg.sec_index;
    assign SEC_WDATA = core_reg.sec_wdata;

endmodule // sst_exec

/* tb/sst_exec_properties.sv */
// Concurrent checks for the subtract, swap and table execution unit
`timescale 1ns/1ps
module sst_exec_properties
    import sst_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic OP_VALID,
    input wire logic [2:0] OP_CODE,
    input wire logic OP_DEST,
    input wire logic [7:0] OP_IMMEDIATE,
    input wire logic [3:0] OP_SEC_INDEX,
    input wire logic [7:0] FILE_RDATA,
    input wire logic [2:0] TABLE_HIGH_POINTER,
    input wire logic [13:0] ROM_DATA,
    input wire logic BUSY,
    input wire logic [7:0] ACCUMULATOR,
    input wire logic ZERO_FLAG,
    input wire logic DIGIT_CARRY_FLAG,
    input wire logic CARRY_FLAG,
    input wire logic FILE_WE,
    input wire logic [7:0] FILE_WDATA,
    input wire logic [10:0] ROM_ADDR,
    input wire logic [5:0] TABLE_HIGH_DATA,
    input wire logic [7:0] TIMER0_MODE_REGISTER,
    input wire logic SEC_WE,
    input wire logic [3:0] SEC_INDEX,
    input wire logic [7:0] SEC_WDATA
);
    // ------------------------------------------------------------
    // Expected results of the operation now presented
    // ------------------------------------------------------------
    logic tk;
    logic [7:0] fd, id, sw;
    logic [2:0] ff, fi, fl;
    assign tk = OP_VALID && !BUSY;
    assign fd = FILE_RDATA - ACCUMULATOR;
    assign id = OP_IMMEDIATE - ACCUMULATOR;
    assign sw = {FILE_RDATA[3:0], FILE_RDATA[7:4]};
    assign ff = {fd == 8'h00, FILE_RDATA[3:0] >= ACCUMULATOR[3:0],
                 FILE_RDATA >= ACCUMULATOR};
    assign fi = {id == 8'h00, OP_IMMEDIATE[3:0] >= ACCUMULATOR[3:0],
                 OP_IMMEDIATE >= ACCUMULATOR};
    assign fl = {ZERO_FLAG, DIGIT_CARRY_FLAG, CARRY_FLAG};
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    sub_to_accum_a: assert property (tk && OP_CODE == 3'h1 && !OP_DEST
        |=> ACCUMULATOR == $past(fd)) else $error("file sub result wrong");
    sub_file_wr_a: assert property (tk && OP_CODE == 3'h1 && OP_DEST
        |=> FILE_WE && FILE_WDATA == $past(fd)) else $error("file sub wrong");
    sub_flags_a: assert property (tk && OP_CODE == 3'h1
        |=> fl == $past(ff)) else $error("file sub flags wrong");
    sub_imm_a: assert property (tk && OP_CODE == 3'h2
        |=> ACCUMULATOR == $past(id) && fl == $past(fi))
        else $error("immediate sub wrong");
    swap_accum_a: assert property (tk && OP_CODE == 3'h3 && !OP_DEST
        |=> ACCUMULATOR == $past(sw) && $stable(fl)) else $error("swap wrong");
    swap_file_a: assert property (tk && OP_CODE == 3'h3 && OP_DEST
        |=> FILE_WE && FILE_WDATA == $past(sw)) else $error("swap wr wrong");
    table_addr_a: assert property (tk && OP_CODE == 3'h4 |=> BUSY
        && ROM_ADDR == {$past(TABLE_HIGH_POINTER), $past(ACCUMULATOR)}
        ##1 !BUSY) else $error("table address or timing wrong");
    table_data_a: assert property ($fell(BUSY) |->
        {TABLE_HIGH_DATA, ACCUMULATOR} == $past(ROM_DATA))
        else $error("table data wrong");
    sec_load_a: assert property (tk && OP_CODE == 3'h5 && OP_SEC_INDEX
        <= SST_SEC_INDEX_MAX |=> SEC_WE && SEC_WDATA == $past(ACCUMULATOR)
        && SEC_INDEX == $past(OP_SEC_INDEX)) else $error("sec load wrong");
    t0_load_a: assert property (tk && OP_CODE == 3'h6
        |=> TIMER0_MODE_REGISTER == $past(ACCUMULATOR) && $stable(fl))
        else $error("timer0 mode load wrong");
endmodule // sst_exec_properties

bind sst_exec sst_exec_properties i_props (.CLOCK, .RSTN, .OP_VALID,
    .OP_CODE, .OP_DEST, .OP_IMMEDIATE, .OP_SEC_INDEX, .FILE_RDATA,
    .TABLE_HIGH_POINTER, .ROM_DATA, .BUSY, .ACCUMULATOR, .ZERO_FLAG,
    .DIGIT_CARRY_FLAG, .CARRY_FLAG, .FILE_WE, .FILE_WDATA, .ROM_ADDR,
    .TABLE_HIGH_DATA, .TIMER0_MODE_REGISTER, .SEC_WE, .SEC_INDEX, .SEC_WDATA);

/* tb/tb.sv */
// Self-checking bench for the subtract, swap and table execution unit
`timescale 1ns/1ps
module tb
    import sst_pkg::*;
;
    logic CLOCK = 1'b0, RSTN = 1'b0, OP_VALID = 1'b0, OP_DEST = 1'b0;
    logic [2:0] OP_CODE = 3'h0, TABLE_HIGH_POINTER = 3'h0;
    logic [6:0] OP_FILE_ADDR = 7'h00, FILE_WADDR, fa = 7'h00;
    logic [7:0] OP_IMMEDIATE = 8'h00, FILE_RDATA = 8'h00;
    logic [3:0] OP_SEC_INDEX = 4'h0, SEC_INDEX;
    logic [13:0] ROM_DATA = 14'h0000;
    logic BUSY, ZERO_FLAG, DIGIT_CARRY_FLAG, CARRY_FLAG, FILE_WE, SEC_WE;
    logic [7:0] ACCUMULATOR, FILE_WDATA, TIMER0_MODE_REGISTER, SEC_WDATA;
    logic [10:0] ROM_ADDR;
    logic [5:0] TABLE_HIGH_DATA, hd = 6'h00;
    logic [7:0] accum = 8'h00, t0 = 8'h00, fw = 8'h00;
    logic [11:0] sw = 12'h000;
    logic [2:0] fl = 3'h0;
    logic [31:0] seed = 32'h00000053;
    int n_errors = 0, num_checks = 0;

    sst_exec i_dut (.CLOCK, .RSTN, .OP_VALID, .OP_CODE, .OP_DEST,
        .OP_FILE_ADDR, .OP_IMMEDIATE, .OP_SEC_INDEX, .FILE_RDATA,
        .TABLE_HIGH_POINTER, .ROM_DATA, .BUSY, .ACCUMULATOR, .ZERO_FLAG,
        .DIGIT_CARRY_FLAG, .CARRY_FLAG, .FILE_WE, .FILE_WADDR, .FILE_WDATA,
        .ROM_ADDR, .TABLE_HIGH_DATA, .TIMER0_MODE_REGISTER, .SEC_WE,
        .SEC_INDEX, .SEC_WDATA);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Result with {zero, digit carry, carry} above it
    function automatic logic [10:0] f_sub(logic [7:0] a, logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {d == 8'h00, a[3:0] >= b[3:0], a >= b, d};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic op(input logic [2:0] c, input logic d, input logic [7:0] r,
                      input logic [7:0] im, input logic [3:0] ix,
                      input logic [13:0] rom);
        logic [10:0] s;
        logic [7:0] res;
        logic fwe, swe;
        OP_VALID = 1'b1;
        OP_CODE = c;
        OP_DEST = d;
        OP_FILE_ADDR = r[6:0];
        FILE_RDATA = r;
        OP_IMMEDIATE = im;
        OP_SEC_INDEX = ix;
        TABLE_HIGH_POINTER = im[2:0];
        ROM_DATA = ~rom;
        s = (c == 3'h2) ? f_sub(im, accum) : f_sub(r, accum);
        res = (c == 3'h3) ? {r[3:0], r[7:4]} : s[7:0];
        fwe = (c == 3'h1 || c == 3'h3) && d;
        swe = c == 3'h5 && ix <= SST_SEC_INDEX_MAX;
        @(posedge CLOCK);
        #1;
        if (c == 3'h4) begin
            chk({BUSY, ROM_ADDR}, {1'b1, im[2:0], accum});
            ROM_DATA = rom;
            OP_CODE = 3'h6;
            @(posedge CLOCK);
            #1;
            {hd, accum} = rom;
        end
        if ((c == 3'h1 || c == 3'h3) && !d || c == 3'h2) accum = res;
        if (c == 3'h1 || c == 3'h2) fl = s[10:8];
        if (c == 3'h6) t0 = accum;
        if (fwe) {fa, fw} = {r[6:0], res};
        if (swe) sw = {ix, accum};
        chk({BUSY, ACCUMULATOR, ZERO_FLAG, DIGIT_CARRY_FLAG, CARRY_FLAG},
            {1'b0, accum, fl});
        chk({TABLE_HIGH_DATA, TIMER0_MODE_REGISTER}, {hd, t0});
        chk({FILE_WE, FILE_WADDR, FILE_WDATA}, {fwe, fa, fw});
        chk({SEC_WE, SEC_INDEX, SEC_WDATA}, {swe, sw});
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        forever #4 CLOCK = ~CLOCK;
    end

    initial begin
        repeat (3000) @(posedge CLOCK);
        n_errors++;
        results();
    end

    initial begin
        logic [31:0] v, w;
        repeat (4) @(posedge CLOCK);
        #1;
        RSTN = 1'b1;
        op(3'h2, 1'b0, 8'h00, 8'h06, 4'h0, 14'h0000);
        op(3'h1, 1'b0, 8'h05, 8'h00, 4'h0, 14'h0000);
        op(3'h1, 1'b1, 8'hFF, 8'h00, 4'h0, 14'h0000);
        op(3'h3, 1'b1, 8'hA5, 8'h00, 4'h0, 14'h0000);
        op(3'h3, 1'b0, 8'hA5, 8'h00, 4'h0, 14'h0000);
        op(3'h4, 1'b0, 8'h00, 8'h02, 4'h0, 14'h35AA);
        op(3'h5, 1'b0, 8'h00, 8'h00, 4'hE, 14'h0000);
        op(3'h5, 1'b0, 8'h00, 8'h00, 4'hF, 14'h0000);
        op(3'h6, 1'b0, 8'h00, 8'h00, 4'h0, 14'h0000);
        op(3'h7, 1'b1, 8'h11, 8'h22, 4'h3, 14'h0000);
        repeat (300) begin
            v = rnd();
            w = rnd();
            op(v[2:0], v[3], v[15:8], v[23:16], v[27:24], w[13:0]);
        end
        OP_VALID = 1'b0;
        results();
    end
endmodule // tb
